// *** hw/sarq_defs.svh ***
// Constants of the successive approximation sequencer.
`ifndef SARQ_DEFS_SVH
`define SARQ_DEFS_SVH
`define SARQ_NBITS 10
`define SARQ_CNT_W 4
`define SARQ_LAST_IDX 4'h0
`define SARQ_MSB_IDX 4'h9
`define SARQ_MSB_TRIAL 10'h200
`define SARQ_START_MIN_NS 30
`define SARQ_CLK_NS 25
`define SARQ_START_MIN_CYC ((`SARQ_START_MIN_NS + `SARQ_CLK_NS - 1) / `SARQ_CLK_NS)
`define SARQ_CODE_BIN 2'h0
`define SARQ_CODE_OFFS 2'h1
`define SARQ_CODE_TWOS 2'h2
`define SARQ_CODE_BCD 2'h3
`endif

// *** hw/sarq_pkg.sv ***
// Types of the successive approximation sequencer.
package sarq_pkg;
  typedef enum logic [1:0] {
    SARQ_BIN,
    SARQ_OFFS,
    SARQ_TWOS,
    SARQ_BCD
  } sarq_code_t;
  typedef struct packed {
    logic [9:0] bits;
    logic busy;
    logic serial;
  } sarq_result_t;
endpackage : sarq_pkg

// *** hw/sarq_seq.sv ***
// Sequencer logic of the successive approximation converter.
`timescale 1ns/10ps
`include "sarq_defs.svh"
module sarq_seq (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic start,
  input wire logic cmp_high,
  input wire sarq_pkg::sarq_code_t code_sel,
  output logic busy,
  output logic serial_out,
  output logic [9:0] par_out,
  output logic [9:0] trial_out
);
  import sarq_pkg::*;

  typedef enum logic {SARQ_IDLE, SARQ_CONV} sarq_state_t;

  sarq_state_t state;
  logic [`SARQ_CNT_W-1:0] idx;
  logic [9:0] sar;

  // Codes a result as binary, offset binary, twos complement or two BCD digits.
  function automatic logic [9:0] sarq_code(input logic [9:0] v, input sarq_code_t c);
    logic [9:0] r;
    logic [9:0] n;
    r = v;
    n = (v > 10'h3e7) ? 10'h3e7 : v;
    unique case (c)
      SARQ_BIN: r = v;
      SARQ_OFFS: r = v;
      SARQ_TWOS: r = {~v[9], v[8:0]};
      SARQ_BCD: r = {2'h0, 4'((n / 10'd10) % 10'd10), 4'(n % 10'd10)};
    endcase
    return r;
  endfunction : sarq_code

  // Decides the bit under trial and sets the next trial bit.
  function automatic logic [9:0] sarq_step(input logic [9:0] s,
      input logic [`SARQ_CNT_W-1:0] i, input logic c);
    logic [9:0] r;
    r = s;
    if (c) begin
      r[i] = 1'b0;
    end
    if (i != `SARQ_LAST_IDX) begin
      r[i - 4'h1] = 1'b1;
    end
    return r;
  endfunction : sarq_step

  // Sequencing of a conversion.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state <= SARQ_IDLE;
      idx <= `SARQ_MSB_IDX;
      sar <= 10'h000;
      busy <= 1'b0;
    end else begin
      unique case (state)
        SARQ_IDLE: begin
          if (start) begin
            state <= SARQ_CONV;
            busy <= 1'b1;
            idx <= `SARQ_MSB_IDX;
            sar <= `SARQ_MSB_TRIAL;
          end
        end
        SARQ_CONV: begin
          sar <= sarq_step(sar, idx, cmp_high);
          if (idx == `SARQ_LAST_IDX) begin
            state <= SARQ_IDLE;
            busy <= 1'b0;
          end else begin
            idx <= idx - 4'h1;
          end
        end
      endcase
    end
  end

  // Serial and parallel result presentation.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      serial_out <= 1'b0;
      par_out <= 10'h000;
      trial_out <= 10'h000;
    end else begin
      if (state == SARQ_CONV) begin
        serial_out <= sar[idx] & ~cmp_high;
      end
      if (state == SARQ_CONV && idx == `SARQ_LAST_IDX) begin
        par_out <= sarq_code(sarq_step(sar, idx, cmp_high), code_sel);
      end
      if (state == SARQ_IDLE && start) begin
        trial_out <= `SARQ_MSB_TRIAL;
      end else if (state == SARQ_CONV) begin
        trial_out <= sarq_step(sar, idx, cmp_high);
      end
    end
  end

  int unsigned conv_cnt;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      conv_cnt <= 0;
    end else begin
      conv_cnt <= busy ? conv_cnt + 1 : 0;
    end
  end

  property p_busy_len;
    @(posedge clk) disable iff (sys_rst) $rose(busy) |-> busy [*8] ##1 busy ##1 busy ##1 !busy;
  endproperty
  a_busy_len: assert property (p_busy_len) else $error("busy length wrong");

  property p_busy_rise;
    @(posedge clk) disable iff (sys_rst) (!busy && start) |=> busy;
  endproperty
  a_busy_rise: assert property (p_busy_rise) else $error("busy not raised");

  property p_msb_trial;
    @(posedge clk) disable iff (sys_rst) $rose(busy) |-> sar == 10'h200;
  endproperty
  a_msb_trial: assert property (p_msb_trial) else $error("msb trial not set");

  property p_msb_clear;
    @(posedge clk) disable iff (sys_rst) ($rose(busy) && cmp_high) |=> !sar[9];
  endproperty
  a_msb_clear: assert property (p_msb_clear) else $error("msb not cleared");

  property p_msb_keep;
    @(posedge clk) disable iff (sys_rst) ($rose(busy) && !cmp_high) |=> sar[9] && sar[8];
  endproperty
  a_msb_keep: assert property (p_msb_keep) else $error("msb not kept");

  property p_serial;
    @(posedge clk) disable iff (sys_rst) $rose(busy) |=> serial_out == sar[9];
  endproperty
  a_serial: assert property (p_serial) else $error("serial bit wrong");

  property p_ignore;
    @(posedge clk) disable iff (sys_rst) (busy && start && idx != 4'h0) |=> busy;
  endproperty
  a_ignore: assert property (p_ignore) else $error("start not ignored");

  property p_count;
    @(posedge clk) disable iff (sys_rst) busy |-> conv_cnt < 10;
  endproperty
  a_count: assert property (p_count) else $error("conversion too long");

  property p_bin;
    @(posedge clk) disable iff (sys_rst)
      (state == SARQ_CONV && idx == 4'h0 && code_sel == SARQ_BIN && !cmp_high)
      |=> par_out == $past(sar);
  endproperty
  a_bin: assert property (p_bin) else $error("binary result wrong");

  property p_trial_dac;
    @(posedge clk) disable iff (sys_rst)
      busy |-> trial_out == sar;
  endproperty
  a_trial_dac: assert property (p_trial_dac) else $error("trial drive lags");

  property p_trial_next;
    @(posedge clk) disable iff (sys_rst)
      (state == SARQ_CONV && idx != `SARQ_LAST_IDX) |=> trial_out[$past(idx) - 4'h1];
  endproperty
  a_trial_next: assert property (p_trial_next) else $error("next trial bit not set");

  property p_idx_step;
    @(posedge clk) disable iff (sys_rst)
      (state == SARQ_CONV && idx != `SARQ_LAST_IDX) |=> idx == $past(idx) - 4'h1;
  endproperty
  a_idx_step: assert property (p_idx_step) else $error("bit order wrong");

  property p_busy_stay;
    @(posedge clk) disable iff (sys_rst)
      (state == SARQ_CONV && idx != `SARQ_LAST_IDX) |=> busy;
  endproperty
  a_busy_stay: assert property (p_busy_stay) else $error("busy dropped early");

  property p_busy_fall;
    @(posedge clk) disable iff (sys_rst)
      (state == SARQ_CONV && idx == `SARQ_LAST_IDX) |=> !busy;
  endproperty
  a_busy_fall: assert property (p_busy_fall) else $error("busy not dropped");

  property p_serial_bit;
    @(posedge clk) disable iff (sys_rst)
      (state == SARQ_CONV) |=> serial_out == sar[$past(idx)];
  endproperty
  a_serial_bit: assert property (p_serial_bit) else $error("serial bit not decided");

  property p_serial_idle;
    @(posedge clk) disable iff (sys_rst)
      !busy |=> $stable(serial_out);
  endproperty
  a_serial_idle: assert property (p_serial_idle) else $error("serial moved when idle");

  property p_par_hold;
    @(posedge clk) disable iff (sys_rst)
      !(state == SARQ_CONV && idx == `SARQ_LAST_IDX) |=> $stable(par_out);
  endproperty
  a_par_hold: assert property (p_par_hold) else $error("result moved early");

  property p_offs;
    @(posedge clk) disable iff (sys_rst)
      ($fell(busy) && code_sel == SARQ_OFFS) |-> par_out == sar;
  endproperty
  a_offs: assert property (p_offs) else $error("offset result wrong");

  property p_twos;
    @(posedge clk) disable iff (sys_rst)
      ($fell(busy) && code_sel == SARQ_TWOS) |-> par_out == {~sar[9], sar[8:0]};
  endproperty
  a_twos: assert property (p_twos) else $error("twos result wrong");

  c_conv: cover property (@(posedge clk) $fell(busy));
  c_clear: cover property (@(posedge clk) $rose(busy) && cmp_high);
  c_ign: cover property (@(posedge clk) busy && start);
  c_back: cover property (@(posedge clk) $fell(busy) ##1 busy);
  c_twos: cover property (@(posedge clk) $fell(busy) && code_sel == SARQ_TWOS);
endmodule : sarq_seq

// *** verification/sarq_host_model.sv ***
// Model of the analog side: sample-and-hold and comparator.
`timescale 1ns/10ps
module sarq_host_model (
  input wire logic clk,
  input wire logic busy,
  input wire logic [9:0] trial_out,
  input wire logic [9:0] vin,
  output logic cmp_high
);
  logic [9:0] held;
  always_ff @(posedge clk) begin
    if (!busy) held <= vin;
  end
  assign cmp_high = trial_out > held;
endmodule : sarq_host_model

// *** verification/test_sar_adc_conversion_sequencer.sv ***
// Self-checking bench of the conversion sequencer.
`timescale 1ns/10ps
module test_sar_adc_conversion_sequencer;
  import sarq_pkg::*;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic start = 1'b0;
  logic cmp_high;
  sarq_code_t code_sel = SARQ_BIN;
  logic busy;
  logic serial_out;
  logic [9:0] par_out;
  logic [9:0] trial_out;
  logic [9:0] vin = 10'h000;
  int err_count = 0;
  int checked = 0;
  always #12.5 clk = ~clk;
  sarq_seq u_dut (.clk(clk), .sys_rst(sys_rst), .start(start), .cmp_high(cmp_high),
    .code_sel(code_sel), .busy(busy), .serial_out(serial_out), .par_out(par_out),
    .trial_out(trial_out));
  sarq_host_model u_host (.clk(clk), .busy(busy), .trial_out(trial_out), .vin(vin),
    .cmp_high(cmp_high));
  task automatic check(input logic [9:0] seen, input logic [9:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic give_verdict;
    $display("checked=%0d err_count=%0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : give_verdict
  task automatic convert(input logic [9:0] v, input sarq_code_t c, input logic [9:0] exp);
    logic [9:0] n;
    logic [9:0] ser;
    n = 10'h000;
    ser = 10'h000;
    @(posedge clk);
    vin <= v;
    code_sel <= c;
    start <= 1'b1;
    @(posedge clk);
    #1;
    check(trial_out, 10'h200);
    @(posedge clk);
    start <= 1'b0;
    for (int i = 0; i < 10; i++) begin
      #1;
      ser = {ser[8:0], serial_out};
      n = n + {9'h000, busy};
      if (i < 9) @(posedge clk);
    end
    check(n, 10'h009);
    check({9'h000, busy}, 10'h000);
    check(ser, v);
    check(par_out, exp);
    $display("test done vin=%h code=%0d", v, c);
  endtask : convert
  task automatic restart_held(input logic [9:0] v);
    @(posedge clk);
    vin <= v;
    code_sel <= SARQ_BIN;
    start <= 1'b1;
    repeat (11) @(posedge clk);
    #1;
    check({9'h000, busy}, 10'h000);
    check(par_out, v);
    @(posedge clk);
    start <= 1'b0;
    #1;
    check({9'h000, busy}, 10'h001);
    repeat (10) @(posedge clk);
    #1;
    check({9'h000, busy}, 10'h000);
    check(par_out, v);
    $display("test done held start vin=%h", v);
  endtask : restart_held
  task automatic reset_mid(input logic [9:0] v);
    @(posedge clk);
    vin <= v;
    code_sel <= SARQ_BIN;
    start <= 1'b1;
    repeat (2) @(posedge clk);
    start <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
    check({9'h000, busy}, 10'h001);
    @(posedge clk);
    sys_rst <= 1'b1;
    #1;
    check({9'h000, busy}, 10'h000);
    check(trial_out, 10'h000);
    check(par_out, 10'h000);
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    check({9'h000, busy}, 10'h000);
    $display("test done reset in conversion vin=%h", v);
  endtask : reset_mid
  initial begin
    #20000;
    err_count++;
    give_verdict();
  end
  initial begin
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    #1;
    check(par_out, 10'h000);
    check({9'h000, busy}, 10'h000);
    convert(10'h000, SARQ_BIN, 10'h000);
    convert(10'h3ff, SARQ_BIN, 10'h3ff);
    convert(10'h2aa, SARQ_OFFS, 10'h2aa);
    convert(10'h155, SARQ_TWOS, 10'h355);
    convert(10'h201, SARQ_TWOS, 10'h001);
    convert(10'h123, SARQ_BCD, 10'h091);
    convert(10'h3ff, SARQ_BCD, 10'h099);
    restart_held(10'h0f3);
    reset_mid(10'h1c6);
    convert(10'h1c6, SARQ_BIN, 10'h1c6);
    give_verdict();
  end
endmodule : test_sar_adc_conversion_sequencer
